// [rtl/pulse_train_pkg.sv]
// Constants, register map and types shared by the pulse-train scaling block.
package pulse_train_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int MEAS_TIME_MS = 1000;
   localparam int FILT_STEP_MS = 10;
   localparam int MEAS_CYCLES = CLK_HZ / 1000 * MEAS_TIME_MS;
   localparam int STEP_CYCLES = CLK_HZ / 1000 * FILT_STEP_MS;
   localparam logic [26:0] HALF_PERIOD_ACC = 27'(CLK_HZ / 2);
   localparam logic [15:0] MAX_PULSE_HZ = 16'h7d00;
   // Register byte offsets.
   localparam logic [7:0] FUNC_SEL_OFS = 8'h00;
   localparam logic [7:0] IN_SCALE_OFS = 8'h04;
   localparam logic [7:0] IN_GAIN_OFS = 8'h08;
   localparam logic [7:0] IN_BIAS_OFS = 8'h0c;
   localparam logic [7:0] FILTER_OFS = 8'h10;
   localparam logic [7:0] MON_SEL_OFS = 8'h14;
   localparam logic [7:0] OUT_SCALE_OFS = 8'h18;
   localparam logic [7:0] MEAS_FREQ_OFS = 8'h1c;
   localparam logic [7:0] LEVEL_OFS = 8'h20;
   localparam logic [7:0] OUT_FREQ_OFS = 8'h24;
   // Reset values and ranges; percentages in 0.1 percent, filter time in 10 ms.
   localparam logic [2:0] FUNC_SEL_RST = 3'h0;
   localparam logic [2:0] FUNC_SEL_MAX = 3'h4;
   localparam logic [2:0] FUNC_SPEED_FB = 3'h3;
   localparam logic [15:0] IN_SCALE_RST = 16'h05a0;
   localparam logic [15:0] IN_SCALE_MIN = 16'h0064;
   localparam logic [15:0] IN_GAIN_RST = 16'h03e8;
   localparam logic [15:0] IN_GAIN_MAX = 16'h2710;
   localparam logic [15:0] IN_BIAS_RST = 16'h0000;
   localparam logic signed [15:0] IN_BIAS_LIM = 16'sh03e8;
   localparam logic [7:0] FILTER_RST = 8'h0a;
   localparam logic [7:0] FILTER_MAX = 8'hc8;
   localparam logic [9:0] MON_SEL_RST = 10'h066;
   localparam logic [9:0] MON_OUT_FREQ = 10'h066;
   localparam logic [15:0] OUT_SCALE_RST = 16'h05a0;
   localparam logic [15:0] MON_FULL_SCALE = 16'h03e8;
   localparam int FILT_FRAC = 8;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_LEVEL = 4'b0010,
      SEQ_FILTER = 4'b0100,
      SEQ_OUTPUT = 4'b1000
   } seq_t;

   // Monitor codes accepted by the pulse output selector.
   function automatic logic mon_code_ok(input logic [9:0] c);
      return c == 10'h000 || c == 10'h01f || c == 10'h065 || c == 10'h066 ||
         c == 10'h069 || c == 10'h074 || c == 10'h1f5 || c == 10'h1f6 ||
         (c >= 10'h321 && c <= 10'h329);
   endfunction

   function automatic logic [31:0] abs32(input logic signed [31:0] v);
      return v < 0 ? 32'(-v) : 32'(v);
   endfunction
endpackage

// [rtl/pulse_train_scaling.sv]
// Pulse-train input measurement and scaling, and monitor pulse-train output, with APB registers.
//
// Implementation choices: the APB interface to the registers and the register addresses.
module pulse_train_scaling #(
   parameter int MEAS_CYC = pulse_train_pkg::MEAS_CYCLES,
   parameter int STEP_CYC = pulse_train_pkg::STEP_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pulse pins
   input wire logic pulse_input_terminal,
   input wire logic rotation_reverse_in,
   output logic pulse_output_terminal,
   // Drive side
   input wire logic signed [15:0] monitor_level,
   input wire logic [15:0] drive_out_freq,
   output logic [9:0] pulse_output_monitor_select,
   output logic [2:0] pulse_input_function_select,
   output logic signed [15:0] function_level
);
   typedef struct packed {
      logic [1:0] pin_sync;
      logic [1:0] dir_sync;
      logic pin_prev;
      logic [15:0] edges;
      logic [31:0] gate_cnt;
      logic [31:0] step_cnt;
      logic [15:0] freq;
      logic [2:0] func_sel;
      logic [15:0] in_scale;
      logic [15:0] in_gain;
      logic [15:0] in_bias;
      logic [7:0] filt_time;
      logic [9:0] mon_sel;
      logic [15:0] out_scale;
      logic [15:0] raw_level;
      logic [23:0] filt;
      logic [15:0] level;
      logic [15:0] fout;
      logic [26:0] acc;
      logic pulse;
      pulse_train_pkg::seq_t seq;
      logic neg;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } st_t;

   st_t s_q, s_d;
   logic div_start, div_done;
   logic [31:0] div_num, div_q;
   logic [15:0] div_den;
   logic signed [31:0] tmp, sum;
   logic wr_ok;
   logic [15:0] fsel;

   seq_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .start(div_start),
      .dividend(div_num),
      .divisor(div_den),
      .done(div_done),
      .quotient(div_q)
   );

   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32767) return 16'sh7fff;
      if (v < -32768) return 16'sh8000;
      return v[15:0];
   endfunction

   // The divider works on magnitudes, so the sign stripped before it is put back here.
   function automatic logic signed [31:0] signed_quo(input logic neg, input logic [31:0] q);
      return neg ? -signed'(q) : signed'(q);
   endfunction

   always_comb begin
      s_d = s_q;
      div_start = 1'b0;
      div_num = 32'h00000000;
      div_den = 16'h0001;
      tmp = 32'sh0;
      sum = 32'sh0;
      wr_ok = 1'b1;
      fsel = 16'h0000;
      // The pin is sampled twice before the edge detector reads it.
      s_d.pin_sync = {s_q.pin_sync[0], pulse_input_terminal};
      s_d.dir_sync = {s_q.dir_sync[0], rotation_reverse_in};
      s_d.pin_prev = s_q.pin_sync[1];
      // Frequency in Hz is the rising-edge count over a one-second gate.
      if (s_q.pin_sync[1] && !s_q.pin_prev && s_q.edges != 16'hffff) begin
         s_d.edges = s_q.edges + 16'h0001;
      end
      if (s_q.gate_cnt == 32'(MEAS_CYC - 1)) begin
         s_d.gate_cnt = 32'h00000000;
         s_d.freq = s_d.edges;
         s_d.edges = 16'h0000;
      end else begin
         s_d.gate_cnt = s_q.gate_cnt + 32'h00000001;
      end
      // Every step the divider runs level, then filter, then output frequency.
      if (s_q.step_cnt == 32'(STEP_CYC - 1)) begin
         s_d.step_cnt = 32'h00000000;
      end else begin
         s_d.step_cnt = s_q.step_cnt + 32'h00000001;
      end
      unique case (s_q.seq)
         pulse_train_pkg::SEQ_IDLE: begin
            if (s_q.step_cnt == 32'(STEP_CYC - 1)) begin
               tmp = (32'(signed'(s_q.in_gain)) - 32'(signed'(s_q.in_bias)))
                  * 32'(s_q.freq);
               s_d.neg = tmp < 0;
               div_num = pulse_train_pkg::abs32(tmp);
               div_den = s_q.in_scale;
               div_start = 1'b1;
               s_d.seq = pulse_train_pkg::SEQ_LEVEL;
            end
         end
         pulse_train_pkg::SEQ_LEVEL: begin
            if (div_done) begin
               // Zero frequency gives bias, scaling frequency gives gain.
               sum = 32'(signed'(s_q.in_bias)) + signed_quo(s_q.neg, div_q);
               if (s_q.func_sel == pulse_train_pkg::FUNC_SPEED_FB && s_q.dir_sync[1]) begin
                  sum = -sum;
               end
               if (s_q.func_sel > pulse_train_pkg::FUNC_SPEED_FB) begin
                  sum = 32'sh0;
               end
               s_d.raw_level = sat16(sum);
               tmp = (32'(signed'(s_d.raw_level)) <<< pulse_train_pkg::FILT_FRAC)
                  - 32'(signed'(s_q.filt));
               s_d.neg = tmp < 0;
               div_num = pulse_train_pkg::abs32(tmp);
               div_den = {8'h00, s_q.filt_time};
               div_start = 1'b1;
               s_d.seq = pulse_train_pkg::SEQ_FILTER;
            end
         end
         pulse_train_pkg::SEQ_FILTER: begin
            if (div_done) begin
               // Each 10 ms step moves step/T of the remaining error; zero time passes through.
               if (s_q.filt_time == 8'h00) begin
                  s_d.filt = 24'(signed'(s_q.raw_level)) <<< pulse_train_pkg::FILT_FRAC;
               end else begin
                  s_d.filt = 24'(32'(signed'(s_q.filt)) + signed_quo(s_q.neg, div_q));
               end
               s_d.level = s_d.filt[23:8];
               tmp = 32'(monitor_level);
               div_num = tmp < 0 ? 32'h00000000 : 32'(tmp) * 32'(s_q.out_scale);
               div_den = pulse_train_pkg::MON_FULL_SCALE;
               div_start = 1'b1;
               s_d.seq = pulse_train_pkg::SEQ_OUTPUT;
            end
         end
         pulse_train_pkg::SEQ_OUTPUT: begin
            if (div_done) begin
               fsel = div_q > 32'(pulse_train_pkg::MAX_PULSE_HZ) ? 16'hffff : div_q[15:0];
               if (s_q.mon_sel == pulse_train_pkg::MON_OUT_FREQ && s_q.out_scale == 16'h0000) begin
                  fsel = drive_out_freq;
               end else if (s_q.mon_sel == 10'h000 || s_q.mon_sel == 10'h01f) begin
                  fsel = 16'h0000;
               end
               // Output rate is clamped to the pin's limit.
               s_d.fout = fsel > pulse_train_pkg::MAX_PULSE_HZ ?
                  pulse_train_pkg::MAX_PULSE_HZ : fsel;
               s_d.seq = pulse_train_pkg::SEQ_IDLE;
            end
         end
      endcase
      // Phase accumulator toggles the pin twice per output period.
      if (27'(s_q.acc + 27'(s_q.fout)) >= pulse_train_pkg::HALF_PERIOD_ACC) begin
         s_d.acc = 27'(s_q.acc + 27'(s_q.fout) - pulse_train_pkg::HALF_PERIOD_ACC);
         s_d.pulse = ~s_q.pulse;
      end else begin
         s_d.acc = 27'(s_q.acc + 27'(s_q.fout));
      end
      // APB: answer is prepared in the setup cycle, so access lasts one cycle.
      s_d.pready = 1'b0;
      if (psel && !penable) begin
         s_d.pready = 1'b1;
         s_d.pslverr = 1'b0;
         s_d.prdata = 32'h00000000;
         unique case (paddr)
            pulse_train_pkg::FUNC_SEL_OFS: begin
               s_d.prdata = 32'(s_q.func_sel);
               wr_ok = pwdata <= 32'(pulse_train_pkg::FUNC_SEL_MAX);
            end
            pulse_train_pkg::IN_SCALE_OFS: begin
               s_d.prdata = 32'(s_q.in_scale);
               wr_ok = pwdata >= 32'(pulse_train_pkg::IN_SCALE_MIN)
                  && pwdata <= 32'(pulse_train_pkg::MAX_PULSE_HZ);
            end
            pulse_train_pkg::IN_GAIN_OFS: begin
               s_d.prdata = 32'(s_q.in_gain);
               wr_ok = pwdata <= 32'(pulse_train_pkg::IN_GAIN_MAX);
            end
            pulse_train_pkg::IN_BIAS_OFS: begin
               s_d.prdata = 32'(signed'(s_q.in_bias));
               wr_ok = signed'(pwdata) >= -32'(pulse_train_pkg::IN_BIAS_LIM)
                  && signed'(pwdata) <= 32'(pulse_train_pkg::IN_BIAS_LIM);
            end
            pulse_train_pkg::FILTER_OFS: begin
               s_d.prdata = 32'(s_q.filt_time);
               wr_ok = pwdata <= 32'(pulse_train_pkg::FILTER_MAX);
            end
            pulse_train_pkg::MON_SEL_OFS: begin
               s_d.prdata = 32'(s_q.mon_sel);
               wr_ok = pwdata[31:10] == 22'h0
                  && pulse_train_pkg::mon_code_ok(pwdata[9:0]);
            end
            pulse_train_pkg::OUT_SCALE_OFS: begin
               s_d.prdata = 32'(s_q.out_scale);
               wr_ok = pwdata <= 32'(pulse_train_pkg::MAX_PULSE_HZ);
            end
            pulse_train_pkg::MEAS_FREQ_OFS: begin
               s_d.prdata = 32'(s_q.freq);
               wr_ok = 1'b0;
            end
            pulse_train_pkg::LEVEL_OFS: begin
               s_d.prdata = 32'(signed'(s_q.level));
               wr_ok = 1'b0;
            end
            pulse_train_pkg::OUT_FREQ_OFS: begin
               s_d.prdata = 32'(s_q.fout);
               wr_ok = 1'b0;
            end
            default: begin
               wr_ok = 1'b0;
               s_d.pslverr = 1'b1;
            end
         endcase
         // Out-of-range writes are refused whole rather than clipped.
         if (pwrite && !wr_ok) begin
            s_d.pslverr = 1'b1;
         end
      end
      if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
         unique case (paddr)
            pulse_train_pkg::FUNC_SEL_OFS: s_d.func_sel = pwdata[2:0];
            pulse_train_pkg::IN_SCALE_OFS: s_d.in_scale = pwdata[15:0];
            pulse_train_pkg::IN_GAIN_OFS: s_d.in_gain = pwdata[15:0];
            pulse_train_pkg::IN_BIAS_OFS: s_d.in_bias = pwdata[15:0];
            pulse_train_pkg::FILTER_OFS: s_d.filt_time = pwdata[7:0];
            pulse_train_pkg::MON_SEL_OFS: s_d.mon_sel = pwdata[9:0];
            pulse_train_pkg::OUT_SCALE_OFS: s_d.out_scale = pwdata[15:0];
            default: s_d.pslverr = s_q.pslverr;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.seq <= pulse_train_pkg::SEQ_IDLE;
         s_q.func_sel <= pulse_train_pkg::FUNC_SEL_RST;
         s_q.in_scale <= pulse_train_pkg::IN_SCALE_RST;
         s_q.in_gain <= pulse_train_pkg::IN_GAIN_RST;
         s_q.in_bias <= pulse_train_pkg::IN_BIAS_RST;
         s_q.filt_time <= pulse_train_pkg::FILTER_RST;
         s_q.mon_sel <= pulse_train_pkg::MON_SEL_RST;
         s_q.out_scale <= pulse_train_pkg::OUT_SCALE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pulse_output_terminal = s_q.pulse;
   assign pulse_output_monitor_select = s_q.mon_sel;
   assign pulse_input_function_select = s_q.func_sel;
   assign function_level = s_q.level;
endmodule

// [rtl/seq_divider.sv]
// Unsigned restoring divider, one quotient bit per clock.
module seq_divider (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [15:0] divisor,
   // Result
   output logic done,
   output logic [31:0] quotient
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [31:0] quo;
      logic [16:0] rem;
      logic [15:0] dsr;
   } div_t;

   div_t s_q, s_d;
   // One spare bit keeps the borrow apart from the top bit of a large trial difference.
   logic [17:0] trial;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      trial = {1'b0, s_q.rem[15:0], s_q.quo[31]} - {2'b00, s_q.dsr};
      if (start) begin
         s_d.busy = 1'b1;
         s_d.cnt = 6'h20;
         s_d.quo = dividend;
         s_d.rem = 17'h00000;
         s_d.dsr = divisor;
      end else if (s_q.busy) begin
         if (trial[17]) begin
            s_d.rem = {s_q.rem[15:0], s_q.quo[31]};
            s_d.quo = {s_q.quo[30:0], 1'b0};
         end else begin
            s_d.rem = trial[16:0];
            s_d.quo = {s_q.quo[30:0], 1'b1};
         end
         s_d.cnt = s_q.cnt - 6'h01;
         if (s_q.cnt == 6'h01) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;
   assign quotient = s_q.quo;
endmodule

// [tb/pulse_peer.sv]
// Far-side model: a pulse source with its direction line, and a receiver counting output pulses.
module pulse_peer (
   // Clock
   input wire logic pclk,
   // Source control
   input wire logic [7:0] half,
   input wire logic rev,
   // Pins
   input wire logic out_pin,
   output logic in_pin,
   output logic dir_pin,
   output int out_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic out_d;
   initial begin
      in_pin = 1'h0;
      cnt = 8'h0;
      out_d = 1'h0;
      out_edges = 0;
   end
   // The single track carries no sense of rotation, so that travels on its own line.
   assign dir_pin = rev;
   always @(posedge pclk) begin
      out_d <= out_pin;
      if (out_pin && !out_d) out_edges <= out_edges + 1;
      // Shorter halves would be lost in the synchroniser, so the track idles low instead.
      if (half < 8'h3) begin
         in_pin <= 1'h0;
         cnt <= 8'h0;
      end else if (cnt + 8'h1 >= half) begin
         in_pin <= !in_pin;
         cnt <= 8'h0;
      end else cnt <= cnt + 8'h1;
   end
endmodule

// [tb/pulse_train_assertions.sv]
// Concurrent checks on the register port and mirrored selects of the scaling block.
module pulse_train_assertions (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Selects
   input wire logic [9:0] pulse_output_monitor_select,
   input wire logic [2:0] pulse_input_function_select
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic wr_a = psel && penable && pready && pwrite;
   a_ready_first: assert property (psel && penable && $past(psel && !penable)
      |-> pready) else $error("ready missing");
   a_unmapped_addr: assert property (pready && paddr > 8'h27
      |-> pslverr && (pwrite || prdata == 0)) else $error("unmapped access");
   a_scale_range: assert property (wr_a && paddr == 8'h04
      && (pwdata < 32'h64 || pwdata > 32'h7d00) |-> pslverr) else $error("scale accepted");
   a_gain_range: assert property (wr_a && paddr == 8'h08
      && pwdata > 32'h2710 |-> pslverr) else $error("gain accepted");
   a_bias_range: assert property (wr_a && paddr == 8'h0c
      && ($signed(pwdata) > 32'sh3e8 || $signed(pwdata) < -32'sh3e8) |-> pslverr)
      else $error("bias accepted");
   a_filter_range: assert property (wr_a && paddr == 8'h10
      && pwdata > 32'hc8 |-> pslverr) else $error("filter accepted");
   a_mon_code: assert property (pulse_output_monitor_select inside {
      10'h0, 10'h1f, 10'h65, 10'h66, 10'h69, 10'h74, 10'h1f5, 10'h1f6, [10'h321:10'h329]})
      else $error("bad monitor");
   a_mon_write: assert property (wr_a && !pslverr && paddr == 8'h14 |-> ##2
      pulse_output_monitor_select == $past(pwdata[9:0], 2)) else $error("monitor copy");
   a_func_range: assert property (pulse_input_function_select <= 3'h4)
      else $error("bad function");
   a_func_write: assert property (wr_a && !pslverr && paddr == 8'h00 |-> ##2
      pulse_input_function_select == $past(pwdata[2:0], 2)) else $error("function copy");
endmodule

bind pulse_train_scaling pulse_train_assertions chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pulse_output_monitor_select(pulse_output_monitor_select),
   .pulse_input_function_select(pulse_input_function_select));

// [tb/tb_top.sv]
// Self-checking bench for the pulse-train scaling block.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, dir, pout, rev;
   logic [7:0] paddr, half;
   logic [31:0] pwdata, prdata;
   logic signed [15:0] mon_lvl, level;
   logic [15:0] drv_freq;
   logic [9:0] mon_sel;
   logic [2:0] fsel;
   int failures, cmp_count, edges;

   pulse_train_scaling #(.MEAS_CYC(1000), .STEP_CYC(200)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_input_terminal(pin),
      .rotation_reverse_in(dir), .pulse_output_terminal(pout), .monitor_level(mon_lvl),
      .drive_out_freq(drv_freq), .pulse_output_monitor_select(mon_sel),
      .pulse_input_function_select(fsel), .function_level(level));
   pulse_peer peer_u (.pclk(pclk), .half(half), .rev(rev), .out_pin(pout), .in_pin(pin),
      .dir_pin(dir), .out_edges(edges));

   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_of_test;
      if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // For a read, d is the expected word; for a write, the data sent.
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge pclk);
      penable <= 1'h1;
      // The request stands until pready is seen high at a rising edge; only the watchdog ends this.
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      if (!w) chk(prdata, d);
      chk(32'(pslverr), 32'(e));
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic t_defaults;
      acc(1'h0, 8'h00, 32'h0, 1'h0);
      acc(1'h0, 8'h04, 32'h5a0, 1'h0);
      acc(1'h0, 8'h08, 32'h3e8, 1'h0);
      acc(1'h0, 8'h0c, 32'h0, 1'h0);
      acc(1'h0, 8'h10, 32'ha, 1'h0);
      acc(1'h0, 8'h14, 32'h66, 1'h0);
      acc(1'h0, 8'h18, 32'h5a0, 1'h0);
      chk(32'(mon_sel), 32'h66);
   endtask

   task automatic t_refuse;
      for (int c = 0; c < 1024; c++) begin
         acc(1'h1, 8'h14, 32'(c), !(c inside {'h0, 'h1f, 'h65, 'h66, 'h69, 'h74, 'h1f5, 'h1f6,
            ['h321:'h329]}));
      end
      chk(32'(mon_sel), 32'h329);
      acc(1'h1, 8'h04, 32'h63, 1'h1);
      acc(1'h1, 8'h04, 32'h7d01, 1'h1);
      acc(1'h1, 8'h04, 32'h64, 1'h0);
      acc(1'h0, 8'h04, 32'h64, 1'h0);
      acc(1'h1, 8'h08, 32'h2711, 1'h1);
      acc(1'h1, 8'h0c, 32'hfffffc17, 1'h1);
      acc(1'h1, 8'h0c, 32'hfffffc18, 1'h0);
      acc(1'h0, 8'h0c, 32'hfffffc18, 1'h0);
      acc(1'h1, 8'h10, 32'hc9, 1'h1);
      acc(1'h1, 8'h18, 32'h7d01, 1'h1);
      acc(1'h1, 8'h00, 32'h5, 1'h1);
      acc(1'h1, 8'h20, 32'h1, 1'h1);
      acc(1'h0, 8'h40, 32'h0, 1'h1);
   endtask

   task automatic t_level;
      int hs[4] = '{0, 5, 10, 4};
      int fq[4] = '{0, 100, 50, 125};
      int lv[4] = '{-200, 1000, 400, 1300};
      acc(1'h1, 8'h10, 32'h0, 1'h0);
      acc(1'h1, 8'h0c, 32'hffffff38, 1'h0);
      for (int i = 0; i < 4; i++) begin
         half <= 8'(hs[i]);
         wt(2600);
         acc(1'h0, 8'h1c, 32'(fq[i]), 1'h0);
         acc(1'h0, 8'h20, 32'(lv[i]), 1'h0);
         chk(32'(level), 32'(lv[i]));
      end
      half <= 8'h5;
      rev <= 1'h1;
      wt(2600);
      for (int f = 0; f < 5; f++) begin
         acc(1'h1, 8'h00, 32'(f), 1'h0);
         wt(500);
         chk(32'(fsel), 32'(f));
         chk(32'(level), f == 3 ? 32'hfffffc18 : f == 4 ? 32'h0 : 32'h3e8);
      end
      acc(1'h1, 8'h00, 32'h3, 1'h0);
      rev <= 1'h0;
      wt(500);
      chk(32'(level), 32'h3e8);
      acc(1'h1, 8'h00, 32'h0, 1'h0);
   endtask

   task automatic t_filter;
      int n;
      acc(1'h1, 8'h0c, 32'h0, 1'h0);
      half <= 8'h0;
      wt(2600);
      acc(1'h1, 8'h10, 32'ha, 1'h0);
      half <= 8'h5;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (level === 16'sh0 && n < 5000);
      chk(32'(level > 0 && level <= 16'sh64), 32'h1);
      wt(25000);
      chk(32'(level inside {16'sh3e7, 16'sh3e8}), 32'h1);
   endtask

   task automatic ofq(input logic [9:0] m, input logic [15:0] s, input logic [15:0] l,
         input logic [31:0] x);
      acc(1'h1, 8'h14, 32'(m), 1'h0);
      acc(1'h1, 8'h18, 32'(s), 1'h0);
      mon_lvl <= l;
      wt(500);
      acc(1'h0, 8'h24, x, 1'h0);
   endtask

   task automatic t_output;
      int e0;
      drv_freq <= 16'h4d2;
      ofq(10'h65, 16'h7d00, 16'h3e8, 32'h7d00);
      e0 = edges;
      wt(15625);
      chk(32'(edges - e0 inside {[4:6]}), 32'h1);
      ofq(10'h65, 16'h7d00, 16'h7d0, 32'h7d00);
      ofq(10'h65, 16'h5a0, 16'h1f4, 32'h2d0);
      ofq(10'h66, 16'h0, 16'h3e8, 32'h4d2);
      ofq(10'h66, 16'h5a0, 16'h3e8, 32'h5a0);
      ofq(10'h65, 16'h0, 16'h3e8, 32'h0);
      ofq(10'h1f, 16'h5a0, 16'h3e8, 32'h0);
   endtask

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      half = 8'h0;
      rev = 1'h0;
      mon_lvl = 16'sh0;
      drv_freq = 16'h0;
      failures = 0;
      cmp_count = 0;
      wt(20);
      presetn <= 1'h1;
      t_defaults;
      t_refuse;
      t_level;
      t_filter;
      t_output;
      end_of_test;
   end

   // The tests need about 70000 cycles, so this limit only trips on a hang.
   initial begin
      wt(95000);
      failures++;
      end_of_test;
   end
endmodule
